/* clksup_pkg.sv */
// shared constants of the clock supervisor and reset controller
package clksup_pkg;
  // =========================================================
  // clock and timing
  localparam int PCLK_PERIOD_NS = 10;
  localparam int PCLK_MHZ = 100;
  // lowest legal crystal frequency, in kHz
  localparam int XTAL_LOW_KHZ = 1500;
  // highest legal crystal frequency, in MHz
  localparam int XTAL_HIGH_MHZ = 50;
  // longest legal crystal period in pclk cycles, rounded down
  localparam int XTAL_SLOW_CYC = (1000000 / XTAL_LOW_KHZ) / PCLK_PERIOD_NS;
  // shortest legal crystal period in pclk cycles
  localparam int XTAL_FAST_CYC = (1000 / XTAL_HIGH_MHZ) / PCLK_PERIOD_NS;
  // internal fallback oscillator, nominal MHz
  localparam int LIMP_MHZ = 10;
  localparam int LIMP_DIV = PCLK_MHZ / LIMP_MHZ;
  // glitch filter minimum widths, ns; cycles round up
  localparam int RST_FILT_NS = 20;
  localparam int TEST_FILT_NS = 10;
  localparam int RST_FILT_CYC = (RST_FILT_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int TEST_FILT_CYC = (TEST_FILT_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  // reset stretch and pin release counts
  localparam logic [10:0] POR_STRETCH_OSC = 11'd1048;
  localparam logic [10:0] TX_RELEASE_OSC = 11'd1024;
  localparam logic [10:0] WARM_STRETCH_PERIPHERAL_BUS_CLOCK = 11'd8;
  // =========================================================
  // register byte offsets
  localparam logic [11:0] CLK_DIV_OFS = 12'h000;
  localparam logic [11:0] EXTERNAL_CLOCK_OUT_PRE_OFS = 12'h004;
  localparam logic [11:0] FLASH_RD_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h010;
  localparam logic [11:0] IRQ_CLR_OFS = 12'h014;
  localparam logic [11:0] IRQ_EN_OFS = 12'h018;
  localparam logic [11:0] RST_CTRL_OFS = 12'h01c;
  // =========================================================
  // field positions and reset values
  localparam int VBUS_DIV_LSB = 16;
  localparam int VBUS_DIV_MSB = 19;
  localparam int EXTERNAL_CLOCK_OUT_PRE_MSB = 15;
  localparam int FLASH_MODE_MSB = 2;
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_LIMP_BIT = 1;
  localparam int ST_MFG_BIT = 2;
  localparam int ST_IORUN_BIT = 3;
  localparam int EV_FAIL_BIT = 0;
  localparam int EV_WARM_BIT = 1;
  localparam int EV_MFG_BIT = 2;
  localparam int EV_BITS = 3;
  localparam int SW_RST_BIT = 0;
  localparam logic [31:0] CLK_DIV_RST = 32'h0000_0000;
  localparam logic [31:0] EXTERNAL_CLOCK_OUT_PRE_RST = 32'h0000_0000;
  localparam logic [31:0] FLASH_RD_RST = 32'h0000_0000;
  localparam logic [EV_BITS-1:0] IRQ_EN_RST = 3'h0;
  // =========================================================
  // reset sequencer states
  typedef enum logic [1:0] {
    SEQ_POR,
    SEQ_POR_STRETCH,
    SEQ_RUN,
    SEQ_WARM_HOLD
  } seq_state_t;
endpackage

/* pin_filter_if.sv */
// carrier between a reset pin glitch filter and its user
`timescale 1ns/100ps
interface pin_filter_if;
  logic raw;
  logic clean;
  logic fell;
  modport filt (input raw, output clean, output fell);
  modport user (output raw, input clean, input fell);
endinterface // pin_filter_if

/* pin_glitch_filter.sv */
// glitch filter for a slow control pin: accepts a level held FILT_CYC cycles
`timescale 1ns/100ps
module pin_glitch_filter #(
  parameter int FILT_CYC = 2,
  parameter logic RST_LEVEL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  pin_filter_if.filt pin
);
  logic clean_reg;
  logic [3:0] run_reg;
  logic [3:0] run_next;
  logic differs;
  logic accept;

  // =========================================================
  // run length of the level that differs from the output
  assign differs = pin.raw != clean_reg;
  assign accept = differs && (run_reg == 4'(FILT_CYC - 1));
  assign run_next = (differs && !accept) ? run_reg + 4'h1 : 4'h0;
  assign pin.clean = clean_reg;
  assign pin.fell = accept && !pin.raw;

  // any return to the old level restarts the count, so short pulses vanish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_reg <= RST_LEVEL;
      run_reg <= 4'h0;
    end else begin
      run_reg <= run_next;
      if (accept) begin
        clean_reg <= pin.raw;
      end
    end
  end

  // =========================================================
  // a single-cycle opposite level never reaches the output when the filter is wider
  sequence one_cycle_blip;
    (pin.raw != clean_reg) ##1 (pin.raw == clean_reg);
  endsequence
  chk_filter_short_blip: assert property (
    @(posedge pclk) disable iff (!presetn)
    (FILT_CYC > 1 && run_reg == 4'h0) ##0 one_cycle_blip |-> $stable(clean_reg))
    else $error("filter passed a pulse shorter than its width");
  // a new level held two cycles is always taken; covers widths of one and two
  chk_filter_long_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (differs && run_reg == 4'h0) ##1 (pin.raw == $past(pin.raw))
    |=> clean_reg == $past(pin.raw))
    else $error("held level not accepted by the filter");
endmodule // pin_glitch_filter

/* clock_supervisor.sv */
// clock supervisor, reset sequencer, pin release and clock dividers on APB
//
// Overview of operation
// - out-of-window crystal sets fail flag, limp mode
// - fail flag and limp latch until power-on
// - warm reset held 1048 oscillator cycles after power-on
// - other resets hold warm reset 8 bus cycles
// - power-on pin filters pulses below 20 ns
// - warm reset pin filters pulses below 20 ns
// - other pins high impedance through power-on reset
// - bus transmit pins drive high by 1024 cycles
// - bus transmit enables drive high at release
// - input pulls off during power-on, then default
// - reset and test pin pulls always active
// - test pin filters pulses below 10 ns
// - external clock is bus clock divided by N
// - bus clock divider ratio 1 to 16
// - external clock phases each about half period
`timescale 1ns/100ps
module clock_supervisor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_input,
  input wire logic power_on_reset_n,
  input wire logic warm_reset_n,
  input wire logic factory_test_pin,
  output logic crystal_fail_flag,
  output logic limp_mode,
  output logic peripheral_bus_clock,
  output logic external_clock_out,
  output logic [2:0] flash_read_mode,
  output logic warm_reset_out,
  output logic warm_reset_oe,
  output logic warm_domain_reset_n,
  output logic io_release,
  output logic vehicle_bus_tx_a,
  output logic vehicle_bus_tx_a_oe,
  output logic vehicle_bus_tx_b,
  output logic vehicle_bus_tx_b_oe,
  output logic vehicle_bus_tx_enable_a,
  output logic vehicle_bus_tx_enable_a_oe,
  output logic vehicle_bus_tx_enable_b,
  output logic vehicle_bus_tx_enable_b_oe,
  output logic pull_enable,
  output logic reset_pin_pull_enable,
  output logic factory_test_mode,
  output logic irq
);
  // =========================================================
  // declarations
  localparam int EB = clksup_pkg::EV_BITS;
  clksup_pkg::seq_state_t state_reg;
  clksup_pkg::seq_state_t state_next;
  logic [31:0] clk_div_reg;
  logic [31:0] external_clock_out_pre_reg;
  logic [31:0] flash_rd_reg;
  logic [EB-1:0] irq_stat_reg;
  logic [EB-1:0] irq_en_reg;
  logic [31:0] prdata_reg;
  logic fail_reg;
  logic limp_reg;
  logic xtal_reg;
  logic [6:0] mon_reg;
  logic [3:0] limp_div_reg;
  logic [10:0] seq_cnt_reg;
  logic [10:0] seq_cnt_next;
  logic [10:0] tx_cnt_reg;
  logic io_run_reg;
  logic [3:0] vbus_cnt_reg;
  logic vbus_clk_reg;
  logic [20:0] external_clock_out_cnt_reg;
  logic external_clock_out_reg;
  logic sw_rst_reg;
  pin_filter_if por_pin ();
  pin_filter_if warm_pin ();
  pin_filter_if test_pin ();

  // ceiling of half a period, shared by both dividers
  function automatic logic [20:0] half_up(input logic [20:0] period);
    half_up = (period >> 1) + {20'h0, period[0]};
  endfunction

  // =========================================================
  // pin glitch filters
  assign por_pin.raw = power_on_reset_n;
  assign warm_pin.raw = warm_reset_n;
  assign test_pin.raw = factory_test_pin;
  pin_glitch_filter #(.FILT_CYC(clksup_pkg::RST_FILT_CYC), .RST_LEVEL(1'b0)) u_por_filt (
    .pclk(pclk),
    .presetn(presetn),
    .pin(por_pin)
  );
  pin_glitch_filter #(.FILT_CYC(clksup_pkg::RST_FILT_CYC), .RST_LEVEL(1'b1)) u_warm_filt (
    .pclk(pclk),
    .presetn(presetn),
    .pin(warm_pin)
  );
  pin_glitch_filter #(.FILT_CYC(clksup_pkg::TEST_FILT_CYC), .RST_LEVEL(1'b0)) u_test_filt (
    .pclk(pclk),
    .presetn(presetn),
    .pin(test_pin)
  );

  // =========================================================
  // crystal monitor and oscillator tick
  logic por_active;
  logic xtal_rise;
  logic mon_live;
  logic too_fast;
  logic too_slow;
  logic limp_tick;
  logic osc_tick;
  assign por_active = !por_pin.clean;
  assign xtal_rise = crystal_input && !xtal_reg;
  assign mon_live = !por_active && !fail_reg;
  assign too_fast = xtal_rise && (mon_reg < 7'(clksup_pkg::XTAL_FAST_CYC));
  assign too_slow = mon_reg > 7'(clksup_pkg::XTAL_SLOW_CYC);
  assign limp_tick = limp_div_reg == 4'(clksup_pkg::LIMP_DIV - 1);
  // oscillator cycles come from the crystal until limp mode takes over
  assign osc_tick = limp_reg ? limp_tick : xtal_rise;

  // pclk cycles since the last crystal rise, saturating above the slow limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_reg <= 1'b0;
      mon_reg <= 7'h1;
      limp_div_reg <= 4'h0;
    end else begin
      xtal_reg <= crystal_input;
      limp_div_reg <= limp_tick ? 4'h0 : limp_div_reg + 4'h1;
      // park at the fast limit while idle, so the first rise after release is not too fast
      if (!mon_live) begin
        mon_reg <= 7'(clksup_pkg::XTAL_FAST_CYC);
      end else if (xtal_rise) begin
        mon_reg <= 7'h1;
      end else if (!too_slow) begin
        mon_reg <= mon_reg + 7'h1;
      end
    end
  end

  // sticky fail, cleared only by power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_reg <= 1'b0;
      limp_reg <= 1'b0;
    end else if (por_active) begin
      fail_reg <= 1'b0;
      limp_reg <= 1'b0;
    end else if (mon_live && (too_fast || too_slow)) begin
      fail_reg <= 1'b1;
      limp_reg <= 1'b1;
    end
  end

  // =========================================================
  // reset sequencer
  logic warm_src;
  logic vbus_tick;
  assign warm_src = !warm_pin.clean || sw_rst_reg;

  always_comb begin
    state_next = state_reg;
    seq_cnt_next = seq_cnt_reg;
    unique case (state_reg)
      clksup_pkg::SEQ_POR: begin
        seq_cnt_next = 11'h0;
        if (!por_active) begin
          state_next = clksup_pkg::SEQ_POR_STRETCH;
        end
      end
      clksup_pkg::SEQ_POR_STRETCH: begin
        if (osc_tick) begin
          seq_cnt_next = seq_cnt_reg + 11'h1;
        end
        if (seq_cnt_reg == clksup_pkg::POR_STRETCH_OSC) begin
          state_next = clksup_pkg::SEQ_RUN;
        end
      end
      clksup_pkg::SEQ_RUN: begin
        seq_cnt_next = 11'h0;
        if (warm_src) begin
          state_next = clksup_pkg::SEQ_WARM_HOLD;
        end
      end
      clksup_pkg::SEQ_WARM_HOLD: begin
        // one extra tick so the first, partial bus cycle is not counted
        if (warm_src) begin
          seq_cnt_next = 11'h0;
        end else if (vbus_tick) begin
          seq_cnt_next = seq_cnt_reg + 11'h1;
        end
        if (!warm_src && seq_cnt_reg == clksup_pkg::WARM_STRETCH_PERIPHERAL_BUS_CLOCK + 11'h1) begin
          state_next = clksup_pkg::SEQ_RUN;
        end
      end
    endcase
    if (por_active) begin
      state_next = clksup_pkg::SEQ_POR;
      seq_cnt_next = 11'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= clksup_pkg::SEQ_POR;
      seq_cnt_reg <= 11'h0;
    end else begin
      state_reg <= state_next;
      seq_cnt_reg <= seq_cnt_next;
    end
  end

  // oscillator cycles since power-on release, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_reg <= 11'h0;
      io_run_reg <= 1'b0;
    end else if (por_active) begin
      tx_cnt_reg <= 11'h0;
      io_run_reg <= 1'b0;
    end else begin
      if (osc_tick && tx_cnt_reg != clksup_pkg::TX_RELEASE_OSC) begin
        tx_cnt_reg <= tx_cnt_reg + 11'h1;
      end
      if (state_reg == clksup_pkg::SEQ_RUN) begin
        io_run_reg <= 1'b1;
      end
    end
  end

  // =========================================================
  // pins
  assign warm_reset_out = 1'b0;
  // warm pin pulled low in every state but run
  assign warm_reset_oe = state_reg != clksup_pkg::SEQ_RUN;
  assign warm_domain_reset_n = state_reg == clksup_pkg::SEQ_RUN;
  // other pins stay held until the stretch is over
  assign io_release = io_run_reg && !por_active;
  assign vehicle_bus_tx_a = 1'b1;
  assign vehicle_bus_tx_b = 1'b1;
  // transmit data drives once the count is reached
  assign vehicle_bus_tx_a_oe = !por_active && tx_cnt_reg == clksup_pkg::TX_RELEASE_OSC; // count clears late
  assign vehicle_bus_tx_b_oe = !por_active && tx_cnt_reg == clksup_pkg::TX_RELEASE_OSC;
  assign vehicle_bus_tx_enable_a = 1'b1;
  assign vehicle_bus_tx_enable_b = 1'b1;
  // enables follow the filtered power-on level directly
  assign vehicle_bus_tx_enable_a_oe = !por_active;
  assign vehicle_bus_tx_enable_b_oe = !por_active;
  assign pull_enable = !por_active;
  // reset and test pin pulls never switch off
  assign reset_pin_pull_enable = 1'b1;
  assign factory_test_mode = test_pin.clean;
  assign crystal_fail_flag = fail_reg;
  assign limp_mode = limp_reg;

  // =========================================================
  // clock dividers
  logic [3:0] vbus_div;
  logic [20:0] vbus_ratio;
  logic [20:0] external_clock_out_period;
  logic external_clock_out_wrap;
  assign vbus_div = clk_div_reg[clksup_pkg::VBUS_DIV_MSB:clksup_pkg::VBUS_DIV_LSB];
  assign vbus_ratio = {17'h0, vbus_div} + 21'h1;
  assign vbus_tick = vbus_cnt_reg == vbus_div;
  // period of the external clock is the bus ratio times N
  assign external_clock_out_period = 21'(vbus_ratio * ({5'h0, external_clock_out_pre_reg[clksup_pkg::EXTERNAL_CLOCK_OUT_PRE_MSB:0]}
                       + 21'h1));
  assign external_clock_out_wrap = external_clock_out_cnt_reg >= external_clock_out_period - 21'h1;
  assign peripheral_bus_clock = vbus_clk_reg;
  assign external_clock_out = external_clock_out_reg;
  assign flash_read_mode = flash_rd_reg[clksup_pkg::FLASH_MODE_MSB:0];

  // both outputs high for the lower half of their count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_cnt_reg <= 4'h0;
      vbus_clk_reg <= 1'b0;
      external_clock_out_cnt_reg <= 21'h0;
      external_clock_out_reg <= 1'b0;
    end else begin
      vbus_cnt_reg <= vbus_tick ? 4'h0 : vbus_cnt_reg + 4'h1;
      vbus_clk_reg <= {17'h0, vbus_cnt_reg} < half_up(vbus_ratio);
      external_clock_out_cnt_reg <= external_clock_out_wrap ? 21'h0 : external_clock_out_cnt_reg + 21'h1;
      external_clock_out_reg <= external_clock_out_cnt_reg < half_up(external_clock_out_period);
    end
  end

  // =========================================================
  // APB slave, zero wait states
  logic setup;
  logic wr;
  logic hit;
  logic [EB-1:0] events;
  logic [31:0] rd_mux;
  logic test_prev_reg;
  logic fail_prev_reg;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign hit = paddr[11:5] == 7'h0 && paddr[1:0] == 2'h0;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_reg;
  assign irq = |(irq_stat_reg & irq_en_reg);
  assign events = {test_pin.clean && !test_prev_reg, warm_pin.fell, fail_reg && !fail_prev_reg};

  // previous levels for the event edges; reset values match the filter and flag resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_prev_reg <= 1'b0;
      fail_prev_reg <= 1'b0;
    end else begin
      test_prev_reg <= test_pin.clean;
      fail_prev_reg <= fail_reg;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      clksup_pkg::CLK_DIV_OFS: rd_mux = clk_div_reg;
      clksup_pkg::EXTERNAL_CLOCK_OUT_PRE_OFS: rd_mux = external_clock_out_pre_reg;
      clksup_pkg::FLASH_RD_OFS: rd_mux = flash_rd_reg;
      clksup_pkg::STATUS_OFS: rd_mux = {28'h0, io_run_reg, test_pin.clean, limp_reg, fail_reg};
      clksup_pkg::IRQ_STAT_OFS: rd_mux = {29'h0, irq_stat_reg};
      clksup_pkg::IRQ_EN_OFS: rd_mux = {29'h0, irq_en_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  // write data lands at the access edge; read data is caught at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_div_reg <= clksup_pkg::CLK_DIV_RST;
      external_clock_out_pre_reg <= clksup_pkg::EXTERNAL_CLOCK_OUT_PRE_RST;
      flash_rd_reg <= clksup_pkg::FLASH_RD_RST;
      irq_en_reg <= clksup_pkg::IRQ_EN_RST;
      prdata_reg <= 32'h0;
      sw_rst_reg <= 1'b0;
    end else begin
      sw_rst_reg <= wr && paddr == clksup_pkg::RST_CTRL_OFS && pwdata[clksup_pkg::SW_RST_BIT];
      if (setup) begin
        prdata_reg <= rd_mux;
      end
      if (wr && paddr == clksup_pkg::CLK_DIV_OFS) begin
        clk_div_reg <= {12'h0, pwdata[clksup_pkg::VBUS_DIV_MSB:clksup_pkg::VBUS_DIV_LSB], 16'h0};
      end
      if (wr && paddr == clksup_pkg::EXTERNAL_CLOCK_OUT_PRE_OFS) begin
        external_clock_out_pre_reg <= {16'h0, pwdata[clksup_pkg::EXTERNAL_CLOCK_OUT_PRE_MSB:0]};
      end
      if (wr && paddr == clksup_pkg::FLASH_RD_OFS) begin
        flash_rd_reg <= {29'h0, pwdata[clksup_pkg::FLASH_MODE_MSB:0]};
      end
      if (wr && paddr == clksup_pkg::IRQ_EN_OFS) begin
        irq_en_reg <= pwdata[EB-1:0];
      end
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 3'h0;
    end else if (wr && paddr == clksup_pkg::IRQ_CLR_OFS) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[EB-1:0]) | events;
    end else begin
      irq_stat_reg <= irq_stat_reg | events;
    end
  end

  // =========================================================
  // checks
  logic [10:0] por_osc_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_osc_seen <= 11'h0;
    end else if (state_reg != clksup_pkg::SEQ_POR_STRETCH) begin
      por_osc_seen <= 11'h0;
    end else if (osc_tick) begin
      por_osc_seen <= por_osc_seen + 11'h1;
    end
  end
  sequence fail_raised;
    !fail_reg ##1 fail_reg;
  endsequence
  chk_fail_gives_limp: assert property (
    @(posedge pclk) disable iff (!presetn)
    fail_raised |-> limp_reg ##1 limp_reg)
    else $error("fail flag raised without limp mode");
  chk_slow_detect: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mon_live && too_slow) |=> fail_reg)
    else $error("slow crystal not flagged");
  chk_fail_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    (fail_reg && !por_active) |=> fail_reg && limp_reg)
    else $error("fail flag dropped without power-on reset");
  chk_por_stretch_len: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == clksup_pkg::SEQ_POR_STRETCH) ##1 (state_reg == clksup_pkg::SEQ_RUN)
    |-> $past(por_osc_seen) >= clksup_pkg::POR_STRETCH_OSC)
    else $error("warm reset released early after power-on");
  chk_warm_hold_min: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(warm_reset_oe) && $past(state_reg) == clksup_pkg::SEQ_WARM_HOLD
    |-> $past(seq_cnt_reg) > clksup_pkg::WARM_STRETCH_PERIPHERAL_BUS_CLOCK)
    else $error("warm reset shorter than eight bus cycles");
  chk_por_pins_hiz: assert property (
    @(posedge pclk) disable iff (!presetn)
    por_active |-> !io_release && !vehicle_bus_tx_a_oe && !vehicle_bus_tx_enable_b_oe)
    else $error("pin driven during power-on reset");
  chk_tx_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!por_active && tx_cnt_reg == clksup_pkg::TX_RELEASE_OSC) |-> vehicle_bus_tx_b_oe)
    else $error("transmit pin not driven after release count");
  chk_txen_at_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(por_pin.clean) |-> vehicle_bus_tx_enable_a_oe)
    else $error("transmit enable not driven at release");
  chk_pulls_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    pull_enable == !por_active && reset_pin_pull_enable)
    else $error("pull enables wrong for power-on state");
  chk_por_warm_domain: assert property (
    @(posedge pclk) disable iff (!presetn)
    por_active |=> warm_reset_oe && !warm_domain_reset_n)
    else $error("power-on did not assert warm domain");
endmodule // clock_supervisor

/* crystal_board.sv */
// board crystal model for the clock supervisor's crystal pin
`timescale 1ns/100ps
module crystal_board (
  input wire logic pclk,
  input wire logic run,
  output logic crystal_input
);
  int cnt = 0;
  // =====================================================
  // 10 MHz crystal: toggles every 5 pclk, stands still when stopped
  initial crystal_input = 1'b0;
  always @(posedge pclk) begin
    cnt <= run ? (cnt + 1) % 5 : 0;
    if (run && cnt == 4) crystal_input <= ~crystal_input;
  end
endmodule // crystal_board

/* test_clock_supervisor.sv */
// self-checking bench of the clock supervisor with queued read checks
`timescale 1ns/100ps
module test_clock_supervisor;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic power_on_reset_n = 1'b0, warm_reset_n = 1'b1, factory_test_pin = 1'b0, run = 1'b1;
  logic pready, pslverr, crystal_input, crystal_fail_flag, limp_mode, peripheral_bus_clock;
  logic external_clock_out, warm_reset_out, warm_reset_oe, warm_domain_reset_n, io_release;
  logic vehicle_bus_tx_a, vehicle_bus_tx_a_oe, vehicle_bus_tx_b, vehicle_bus_tx_b_oe;
  logic vehicle_bus_tx_enable_a, vehicle_bus_tx_enable_a_oe;
  logic vehicle_bus_tx_enable_b, vehicle_bus_tx_enable_b_oe;
  logic pull_enable, reset_pin_pull_enable, factory_test_mode, irq, sel;
  logic [2:0] flash_read_mode;
  logic [32:0] exp_q[$];
  logic [32:0] q;
  int err_count = 0, total_checks = 0, t, x, n, per, hi;
  wire sig = sel ? external_clock_out : peripheral_bus_clock;
  always #5 pclk = ~pclk;
  clock_supervisor uut (.*);
  crystal_board board (.pclk(pclk), .run(run), .crystal_input(crystal_input));
  // =====================================================
  // shared checks and bus cycles
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er = 1'b0);
    exp_q.push_back({er, e});
    wr(a, 32'h0, 1'b0);
  endtask
  // period and high time of the selected divided clock, in pclk cycles
  task automatic meas(input logic s);
    sel = s;
    hi = 0;
    while (sig !== 1'b0) @(posedge pclk);
    while (sig !== 1'b1) @(posedge pclk);
    while (sig === 1'b1) begin
      hi++;
      @(posedge pclk);
    end
    per = hi;
    while (sig === 1'b0) begin
      per++;
      @(posedge pclk);
    end
  endtask
  task automatic wait_warm;
    while (warm_reset_oe === 1'b1) @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // compare each completed read against the oldest note; edge sees pre-update bus
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      q = exp_q.pop_front();
      chk("prdata", q[31:0], prdata);
      chk("pslverr", {31'h0, q[32]}, {31'h0, pslverr});
    end
  end
  // =====================================================
  // main sequence
  initial begin
    void'($urandom(32'h314a));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("io_release", 32'h0, {31'h0, io_release});
    chk("tx oes", 32'h0, {vehicle_bus_tx_a_oe, vehicle_bus_tx_b_oe});
    chk("tx en oes", 32'h0, {vehicle_bus_tx_enable_a_oe, vehicle_bus_tx_enable_b_oe});
    chk("pulls", 32'h1, {pull_enable, reset_pin_pull_enable});
    chk("warm domain", 32'h4, {warm_reset_oe, warm_domain_reset_n, warm_reset_out});
    power_on_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("tx en", 32'hf, {vehicle_bus_tx_enable_a_oe, vehicle_bus_tx_enable_b_oe,
        vehicle_bus_tx_enable_a, vehicle_bus_tx_enable_b});
    chk("pull after", 32'h2, {pull_enable, io_release});
    for (t = 0; warm_reset_oe === 1'b1 && t < 20000; t++) begin
      if (vehicle_bus_tx_a_oe !== 1'b1 || vehicle_bus_tx_b_oe !== 1'b1) x = t;
      @(posedge pclk);
    end
    chk("tx late", 32'h1, 32'(x + 4 <= 10260));
    chk("por stretch", 32'h1, 32'(t + 4 >= 10470));
    repeat (3) @(posedge pclk);
    chk("tx high", 32'h7, {vehicle_bus_tx_a, vehicle_bus_tx_b, io_release});
    rd(clksup_pkg::CLK_DIV_OFS, 32'h0);
    rd(clksup_pkg::EXTERNAL_CLOCK_OUT_PRE_OFS, 32'h0);
    rd(clksup_pkg::IRQ_EN_OFS, 32'h0);
    rd(12'h020, 32'h0, 1'b1);
    rd(12'h002, 32'h0, 1'b1);
    $display("power on sequence done");
    x = $urandom % 15 + 2;
    n = $urandom % 3 + 1;
    // periodic clock stays on the bus clock source
    // pipeline mode set before any clock raise
    wr(clksup_pkg::FLASH_RD_OFS, 32'h5);
    wr(clksup_pkg::CLK_DIV_OFS, 32'(x - 1) << 16);
    wr(clksup_pkg::EXTERNAL_CLOCK_OUT_PRE_OFS, 32'(n - 1));
    chk("flash mode", 32'h5, {29'h0, flash_read_mode});
    rd(clksup_pkg::CLK_DIV_OFS, 32'(x - 1) << 16);
    meas(1'b0);
    chk("bus period", x, per);
    meas(1'b1);
    chk("ext period", x * n, per);
    chk("ext high", (x * n + 1) / 2, hi);
    $display("dividers done");
    wr(clksup_pkg::RST_CTRL_OFS, 32'h1);
    while (warm_reset_oe !== 1'b1) @(posedge pclk);
    for (t = 0; warm_reset_oe === 1'b1 && t < 5000; t++) @(posedge pclk);
    chk("warm hold", 32'h1, 32'(t >= 8 * x));
    wait_warm();
    wr(clksup_pkg::IRQ_CLR_OFS, 32'h7);
    warm_reset_n <= 1'b0;
    @(posedge pclk);
    warm_reset_n <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(clksup_pkg::IRQ_STAT_OFS, 32'h0);
    warm_reset_n <= 1'b0;
    factory_test_pin <= 1'b1;
    repeat (16) @(posedge pclk);
    chk("test mode", 32'h1, {31'h0, factory_test_mode});
    warm_reset_n <= 1'b1;
    factory_test_pin <= 1'b0;
    wait_warm();
    rd(clksup_pkg::IRQ_STAT_OFS, 32'h6);
    $display("reset pins done");
    wr(clksup_pkg::IRQ_CLR_OFS, 32'h7);
    wr(clksup_pkg::IRQ_EN_OFS, 32'h1);
    run <= 1'b0;
    for (t = 0; t < 100 && crystal_fail_flag !== 1'b1; t++) @(posedge pclk);
    @(posedge pclk);
    chk("fail limp irq", 32'h7, {crystal_fail_flag, limp_mode, irq});
    run <= 1'b1;
    rd(clksup_pkg::STATUS_OFS, 32'hb);
    repeat (60) @(posedge pclk);
    chk("fail kept", 32'h3, {crystal_fail_flag, limp_mode});
    wr(clksup_pkg::IRQ_EN_OFS, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(clksup_pkg::IRQ_EN_OFS, 32'h1);
    wr(clksup_pkg::IRQ_CLR_OFS, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    power_on_reset_n <= 1'b0;
    @(posedge pclk);
    power_on_reset_n <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("por glitch", 32'h1, {31'h0, crystal_fail_flag});
    power_on_reset_n <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("por clear", 32'h1, {crystal_fail_flag, limp_mode, warm_domain_reset_n,
        pull_enable, reset_pin_pull_enable});
    $display("crystal monitor done");
    final_report();
  end
  // cut a hang short; the full run needs about 11k cycles
  initial begin
    #600000;
    err_count++;
    final_report();
  end
endmodule // test_clock_supervisor
